// file: common/sdr_pkg.sv
`default_nettype none
package sdr_pkg;
    localparam logic [31:0] ADDR_STATUS = 32'hFFFF0A00;
    localparam logic [31:0] ADDR_RX = 32'hFFFF0A04;
    localparam logic [31:0] ADDR_TX = 32'hFFFF0A08;
    localparam logic [31:0] ADDR_DIV = 32'hFFFF0A0C;
    localparam logic [31:0] ADDR_CTRL = 32'hFFFF0A10;

    localparam logic [31:0] STATUS_RESET = 32'h00000000;
    localparam logic [7:0] RX_DATA_RESET = 8'h00;
    localparam logic [7:0] TX_DATA_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'h1B;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // status field positions
    localparam int ST_EXCESS = 11;
    localparam int ST_RXLVL_LSB = 8;
    localparam int ST_OVF = 7;
    localparam int ST_RXIRQ = 6;
    localparam int ST_TXIRQ = 5;
    localparam int ST_UF = 4;
    localparam int ST_TXLVL_LSB = 1;
    localparam int ST_ANY = 0;

    // control field positions
    localparam int CT_LOOP = 0;
    localparam int CT_MASTER = 1;
    localparam int CT_CPOL = 2;
    localparam int CT_TFLUSH = 3;
    localparam int CT_CPHA = 4;
    localparam int CT_EN = 5;
    localparam int CT_TMDE = 6;
    localparam int CT_CONT = 11;
    localparam int CT_RFLUSH = 12;
    localparam int CT_THR_LSB = 14;

    localparam int BYTE_BITS = 8;
    localparam int LVL_W = 3;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sdr_bus_req_t;

    typedef struct packed {
        logic sclk;
        logic ss_n;
        logic mosi;
        logic miso;
    } sdr_pin_in_t;

    typedef struct packed {
        logic sclk_o;
        logic sclk_oe;
        logic ss_n_o;
        logic ss_n_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } sdr_pin_out_t;

    localparam sdr_pin_in_t PIN_IDLE = 4'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_STALL = 2'b10
    } sdr_state_t;
endpackage
`default_nettype wire

// file: rtl/sdr_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sdr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int LW = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout,
    output logic [LW-1:0] level,
    output logic full,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH || LW < $clog2(DEPTH + 1)) begin : g_chk
        $error("fifo depth must be a power of two and fit the level width");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp, rp;
    logic push_ok, pop_ok;

    assign full = (level == LW'(DEPTH));
    assign empty = (level == '0);
    // a push into a full fifo is dropped; the caller flags it for the rx fifo only, as overflow
    assign push_ok = push && !full && !flush;
    assign pop_ok = pop && !empty && !flush;
    assign dout = mem[rp];

    always_ff @(posedge mclk) begin
        if (push_ok) begin
            mem[wp] <= din;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            level <= '0;
        end else if (flush) begin
            wp <= '0;
            rp <= '0;
            level <= '0;
        end else begin
            if (push_ok) begin
                wp <= wp + 1'b1;
            end
            if (pop_ok) begin
                rp <= rp + 1'b1;
            end
            if (push_ok && !pop_ok) begin
                level <= level + 1'b1;
            end else if (pop_ok && !push_ok) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/sdr_spi_regs.sv
// Behaviour
// R1: excess flag bit 11 high while rx fifo holds more than threshold count.
// R2: excess flag drops once rx level is at or below threshold count.
// R3: status bits 10:8 give rx fifo byte count, 0 to 4.
// R4: overflow bit 7 sets when a byte arrives into a full rx fifo.
// R5: overflow raises interrupt unless rx fifo flush is on.
// R6: reading status clears bits 7, 6, 5 and 4.
// R7: rx irq bit 6 sets in receive mode when threshold bytes received.
// R8: tx irq bit 5 sets in transmit mode when threshold bytes sent.
// R9: underflow bit 4 sets when a transfer starts with tx fifo empty.
// R10: underflow raises interrupt unless tx fifo flush is on.
// R11: status bits 3:1 give tx fifo byte count, 0 to 4.
// R12: bit 0 sets on any interrupt and clears on status read.
// R13: 32-bit read-only status, reset zero, bits 15:12 read zero.
// R14: 8-bit read-only rx data register, reset zero.
// R15: 8-bit write-only tx data register, reset zero.
// R16: 8-bit write-only clock divider, reset 0x1B.
// R17: 16-bit read-write control register, reset zero.
// R18: master serial clock is core clock over 2 times (1 + divider).
// R19: threshold field picks one to four bytes for both interrupts.
// R20: bytes are 8 bits, most significant bit first, both lines.
// R21: rx data read pops rx fifo; tx data write pushes tx fifo.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module sdr_spi_regs #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sdr_pkg::sdr_bus_req_t bus_req,
    output logic [31:0] rdata,
    input wire sdr_pkg::sdr_pin_in_t pin_i,
    output sdr_pkg::sdr_pin_out_t pin_o
);
    import sdr_pkg::*;

    if (FIFO_DEPTH != 2 && FIFO_DEPTH != 4) begin : g_chk
        $error("status level fields serve fifo depths of 2 or 4 only");
    end

    logic [15:0] ctrl;
    logic [7:0] div;
    logic wr_tx, wr_div, wr_ctrl, rd_st, rd_rx;
    logic [1:0] thr;
    logic [2:0] thr_cnt;
    logic en, master, cpol, cpha, loop, tmde, cont, tx_flush, rx_flush;

    assign wr_tx = bus_req.wr && (bus_req.addr == ADDR_TX);
    assign wr_div = bus_req.wr && (bus_req.addr == ADDR_DIV);
    assign wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);
    assign rd_st = bus_req.rd && (bus_req.addr == ADDR_STATUS);
    assign rd_rx = bus_req.rd && (bus_req.addr == ADDR_RX);

    assign thr = ctrl[CT_THR_LSB +: 2];
    assign thr_cnt = {1'b0, thr} + 3'h1; // R19
    assign en = ctrl[CT_EN];
    assign master = ctrl[CT_MASTER];
    assign cpol = ctrl[CT_CPOL];
    assign cpha = ctrl[CT_CPHA];
    assign loop = ctrl[CT_LOOP];
    assign tmde = ctrl[CT_TMDE];
    assign cont = ctrl[CT_CONT];
    assign tx_flush = ctrl[CT_TFLUSH];
    assign rx_flush = ctrl[CT_RFLUSH];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= bus_req.wdata[15:0]; // R17
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div <= DIV_RESET; // R16
        end else if (wr_div) begin
            div <= bus_req.wdata[7:0]; // R16
        end
    end

    // fifos
    logic [7:0] tx_head, rx_head, rx_byte, rx_next;
    logic [LVL_W-1:0] tx_lvl, rx_lvl;
    logic tx_empty, rx_full, rx_empty;
    logic tx_pop, rx_push, rx_pop;

    // R15 R21
    sdr_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH), .LW(LVL_W)) u_tx_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(tx_flush),
        .push(wr_tx && !tx_flush),
        .pop(tx_pop),
        .din(bus_req.wdata[7:0]),
        .dout(tx_head),
        .level(tx_lvl),
        .full(),
        .empty(tx_empty)
    );

    sdr_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH), .LW(LVL_W)) u_rx_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(rx_flush),
        .push(rx_push),
        .pop(rx_pop),
        .din(rx_byte),
        .dout(rx_head),
        .level(rx_lvl),
        .full(rx_full),
        .empty(rx_empty)
    );

    // pin inputs: a change counts once stages two and three agree
    sdr_pin_in_t s1, s2, s3, pins, pins_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= PIN_IDLE;
            s2 <= PIN_IDLE;
            s3 <= PIN_IDLE;
            pins <= PIN_IDLE;
            pins_q <= PIN_IDLE;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            pins <= (s2 & s3) | (pins & (s2 ^ s3));
            pins_q <= pins;
        end
    end

    logic s_lead, s_trail, ss_fall;
    assign s_lead = (pins.sclk != pins_q.sclk) && (pins_q.sclk == cpol);
    assign s_trail = (pins.sclk != pins_q.sclk) && (pins_q.sclk != cpol);
    assign ss_fall = !pins.ss_n && pins_q.ss_n;

    // shift engine
    sdr_state_t state;
    logic [7:0] divcnt;
    logic tick, sclk_int, ss_n_int, stall_half, started;
    logic [2:0] bitcnt, txcnt;
    logic [7:0] tx_sh, rx_sh;
    logic lead, trail, din, byte_done;
    logic rx_go, m_start, s_start, m_next, load;

    assign tick = (divcnt == div); // R18
    assign lead = (state == ST_SHIFT) && (master ? (tick && sclk_int == cpol) : s_lead);
    assign trail = (state == ST_SHIFT) && (master ? (tick && sclk_int != cpol) : s_trail);
    assign din = loop ? tx_sh[7] : (master ? pins.miso : pins.mosi);
    assign rx_next = {rx_sh[6:0], din}; // R20
    assign byte_done = trail && (bitcnt == 3'h7); // R20
    // with rx flush on in receive mode, reading rx data kicks a master transfer
    assign rx_go = rd_rx && rx_flush && !tmde;
    assign m_start = (state == ST_IDLE) && en && master && ((!tx_empty && !tx_flush) || rx_go);
    assign s_start = en && !master && (((state == ST_IDLE) && ss_fall)
                     || ((state == ST_SHIFT) && byte_done && !pins.ss_n));
    assign m_next = master && byte_done && cont && !tx_empty && !tx_flush;
    assign load = m_start || s_start || m_next;
    assign tx_pop = load && !tx_empty && !tx_flush;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (m_start || s_start) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (!master && (pins.ss_n || !en)) begin
                        state <= ST_IDLE;
                    end else if (master && byte_done && !m_next) begin
                        state <= ST_STALL;
                    end
                end
                ST_STALL: begin
                    // one full serial clock before the next byte may start
                    if (tick && stall_half) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // R18
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divcnt <= 8'h00;
            sclk_int <= 1'b0;
            stall_half <= 1'b0;
        end else begin
            divcnt <= (state != ST_IDLE && !tick) ? divcnt + 8'h01 : 8'h00;
            if (state == ST_SHIFT && master && tick) begin
                sclk_int <= !sclk_int;
            end else if (state != ST_SHIFT) begin
                sclk_int <= cpol;
            end
            stall_half <= (state == ST_STALL) ? (stall_half ^ tick) : 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ss_n_int <= 1'b1;
        end else if (m_start) begin
            ss_n_int <= 1'b0;
        end else if (state == ST_SHIFT && master && byte_done && !m_next) begin
            ss_n_int <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh <= TX_DATA_RESET;
            rx_sh <= RX_DATA_RESET;
            bitcnt <= 3'h0;
            started <= 1'b0;
        end else if (load) begin
            tx_sh <= (tx_empty || tx_flush) ? 8'h00 : tx_head; // R20
            bitcnt <= 3'h0;
            started <= 1'b0;
        end else if (lead) begin
            if (!cpha) begin
                rx_sh <= rx_next;
            end else begin
                if (started) begin
                    tx_sh <= {tx_sh[6:0], 1'b0};
                end
                started <= 1'b1;
            end
        end else if (trail) begin
            bitcnt <= bitcnt + 3'h1;
            if (!cpha) begin
                tx_sh <= {tx_sh[6:0], 1'b0};
            end else begin
                rx_sh <= rx_next;
            end
        end
    end

    assign rx_byte = cpha ? rx_next : rx_sh;
    assign rx_push = byte_done && !rx_flush; // R5
    assign rx_pop = rd_rx && !rx_empty; // R21

    // flag sources
    logic ovf_set, uf_set, rxirq_set, txirq_set, any_set;
    logic [4:0] sticky;
    assign ovf_set = rx_push && rx_full; // R4
    assign uf_set = load && tx_empty; // R9
    assign rxirq_set = rx_push && !rx_full && !tmde && (rx_lvl >= {1'b0, thr}); // R7 R19
    assign txirq_set = byte_done && tmde && (txcnt + 3'h1 == thr_cnt); // R8 R19
    assign any_set = ovf_set || (uf_set && !tx_flush) || rxirq_set || txirq_set; // R5 R10 R12

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txcnt <= 3'h0;
        end else if (!tmde || txirq_set) begin
            txcnt <= 3'h0;
        end else if (byte_done) begin
            txcnt <= txcnt + 3'h1;
        end
    end

    // a set in the same cycle as the status read survives it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sticky <= 5'h00;
        end else begin
            sticky <= (sticky & ~{5{rd_st}}) | {ovf_set, rxirq_set, txirq_set, uf_set, any_set}; // R6 R12
        end
    end

    logic [31:0] status;
    always_comb begin
        status = STATUS_RESET; // R13
        status[ST_EXCESS] = (rx_lvl > thr_cnt); // R1 R2
        status[ST_RXLVL_LSB +: LVL_W] = rx_lvl; // R3
        status[ST_OVF] = sticky[4];
        status[ST_RXIRQ] = sticky[3];
        status[ST_TXIRQ] = sticky[2];
        status[ST_UF] = sticky[1];
        status[ST_TXLVL_LSB +: LVL_W] = tx_lvl; // R11
        status[ST_ANY] = sticky[0];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_STATUS: rdata <= status; // R13
                ADDR_RX: rdata <= {24'h000000, rx_head}; // R14
                ADDR_CTRL: rdata <= {16'h0000, ctrl}; // R17
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    always_comb begin
        pin_o.sclk_o = sclk_int;
        pin_o.sclk_oe = en && master;
        pin_o.ss_n_o = ss_n_int;
        pin_o.ss_n_oe = en && master;
        pin_o.mosi_o = tx_sh[7]; // R20
        pin_o.mosi_oe = en && master;
        pin_o.miso_o = tx_sh[7];
        pin_o.miso_oe = en && !master && !pins.ss_n;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_excess_set: assert property (rd_st && rx_lvl > thr_cnt |=> rdata[ST_EXCESS]) // R1
        else $error("excess flag missing");
    a_excess_clear: assert property (rd_st && rx_lvl <= thr_cnt |=> !rdata[ST_EXCESS]) // R2
        else $error("excess flag stuck");
    a_rx_level: assert property (rd_st |=> rdata[10:8] == $past(rx_lvl) && rdata[10:8] <= 3'h4) // R3
        else $error("rx level wrong");
    a_ovf_flag: assert property (ovf_set |=> sticky[4] && sticky[0]) // R4
        else $error("overflow not flagged");
    a_status_clear: assert property (rd_st && !any_set && !uf_set |=> sticky == 5'h00) // R6
        else $error("status read did not clear flags");
    a_rx_irq: assert property (rxirq_set |=> sticky[3]) // R7
        else $error("rx irq not set");
    a_tx_irq: assert property (byte_done && tmde && txcnt == {1'b0, thr} && !rd_st |=> sticky[2]) // R8
        else $error("tx irq not set");
    a_underflow: assert property (load && tx_empty |=> sticky[1]) // R9
        else $error("underflow not flagged");
    a_uf_irq: assert property (load && tx_empty && !tx_flush |=> sticky[0]) // R10
        else $error("underflow irq missing");
    a_tx_level: assert property (rd_st |=> rdata[3:1] == $past(tx_lvl) && rdata[15:12] == 4'h0) // R11 R13
        else $error("tx level wrong");
    a_div_write: assert property (wr_div |=> div == $past(bus_req.wdata[7:0])) // R16
        else $error("divider not written");
    a_sclk_half: assert property (state == ST_SHIFT && master && $changed(sclk_int) |-> $past(divcnt) == div) // R18
        else $error("serial clock half period wrong");
    a_msb_first: assert property (load && !tx_empty && !tx_flush |=> pin_o.mosi_o == $past(tx_head[7])) // R20
        else $error("msb not first");
    a_rx_pop: assert property (rx_pop && !rx_push && !rx_flush |=> rx_lvl == $past(rx_lvl) - 3'h1) // R21
        else $error("rx read did not pop");

    c_overflow: cover property (ovf_set);
    c_tx_irq: cover property (txirq_set);
    c_slave_byte: cover property (!master && byte_done);
    c_underflow: cover property (uf_set);
endmodule
`default_nettype wire

// file: testbench/sdr_spi_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-side slave, clock mode 0: drives on the falling edge, samples on the rising edge
module sdr_spi_slave_model (
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output int n_done
);
    logic [7:0] sh_out;
    logic [7:0] sh_in;
    logic [7:0] got [0:7];
    int nb;

    initial begin
        miso = 1'b0;
        n_done = 0;
        nb = 0;
        sh_out = 8'h00;
        sh_in = 8'h00;
    end

    // each reply differs per byte so a stuck or reordered fifo shows up
    always @(negedge ss_n) begin
        sh_out = 8'hC3 - 8'(n_done);
        miso = sh_out[7];
        nb = 0;
    end

    always @(posedge sclk) begin
        if (!ss_n && nb < 8) begin
            sh_in = {sh_in[6:0], mosi};
            nb = nb + 1;
            if (nb == 8) begin
                got[n_done[2:0]] = sh_in;
                n_done = n_done + 1;
            end
        end
    end

    always @(negedge sclk) begin
        if (!ss_n && nb < 8) begin
            sh_out = {sh_out[6:0], 1'b0};
            miso = sh_out[7];
        end
    end

    // deselected: the line flips to the inverse of the last bit left on it
    always @(posedge ss_n) begin
        miso = ~miso;
    end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sdr_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    sdr_bus_req_t bus_req = '0;
    logic [31:0] rdata;
    sdr_pin_in_t pin_i;
    sdr_pin_out_t pin_o;
    logic sclk_w, ss_w, mosi_w, miso_w, slv_miso;
    // far-side master lines, used only while the block is a slave
    logic m_sclk = 1'b0;
    logic m_ss_n = 1'b1;
    logic m_mosi = 1'b0;
    int n_mismatch = 0;
    int tests_run = 0;
    int slv_done;
    logic [7:0] txb [0:4] = '{8'h81, 8'h5A, 8'hFF, 8'h00, 8'h3C};
    logic [31:0] addrs [0:5] = '{ADDR_STATUS, ADDR_RX, ADDR_TX, ADDR_DIV, ADDR_CTRL, 32'hFFFF0A14};

    always #25 mclk = ~mclk;

    assign sclk_w = pin_o.sclk_oe ? pin_o.sclk_o : m_sclk;
    assign ss_w = pin_o.ss_n_oe ? pin_o.ss_n_o : m_ss_n;
    assign mosi_w = pin_o.mosi_oe ? pin_o.mosi_o : m_mosi;
    assign miso_w = pin_o.miso_oe ? pin_o.miso_o : slv_miso;
    assign pin_i = {sclk_w, ss_w, mosi_w, miso_w};

    sdr_spi_regs #(.FIFO_DEPTH(4)) u_dut (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
        .pin_i(pin_i), .pin_o(pin_o));
    sdr_spi_slave_model u_slave (.sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w), .miso(slv_miso), .n_done(slv_done));

    task automatic results();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        tests_run++;
        if ((got & mask) !== (exp & mask)) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] mask);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        @(posedge mclk);
        chk(rdata, exp, mask);
    endtask

    // the link counts as idle once slave select has stayed high well past a stall
    task automatic wait_idle();
        int q;
        int t;
        q = 0;
        t = 0;
        while (q < 300 && t < 20000) begin
            @(posedge mclk);
            q = (pin_o.ss_n_o === 1'b1) ? q + 1 : 0;
            t++;
        end
        chk(32'(t < 20000), 32'h1, 32'h1);
    endtask

    task automatic measure(input int exp);
        int n;
        @(posedge pin_o.sclk_o);
        n = 0;
        while (pin_o.sclk_o === 1'b1 && n < 2000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (pin_o.sclk_o === 1'b0 && n < 2000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(32'(n), 32'(exp), 32'hFFFFFFFF);
    endtask

    task automatic t_reset_map();
        for (int i = 0; i < 6; i++) begin
            rchk(addrs[i], 32'h0, 32'hFFFFFFFF);
        end
        wr(ADDR_STATUS, 32'hFFFFFFFF);
        rchk(ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
    endtask

    task automatic t_tx_fill();
        for (int k = 0; k < 5; k++) begin
            wr(ADDR_TX, {24'h0, txb[k]});
            rchk(ADDR_STATUS, 32'((k < 4 ? k + 1 : 4) << 1), 32'hFFFFFFFF);
        end
    endtask

    task automatic t_rx_path();
        wr(ADDR_CTRL, 32'h0022);
        measure(56);
        wait_idle();
        rchk(ADDR_STATUS, 32'h00000C41, 32'hFFFFFFFF);
        rchk(ADDR_STATUS, 32'h00000C00, 32'hFFFFFFFF);
        rchk(ADDR_CTRL, 32'h0022, 32'hFFFFFFFF);
        wr(ADDR_TX, {24'h0, txb[4]});
        wait_idle();
        // whether a refused push re-arms the receive flag is left open
        rchk(ADDR_STATUS, 32'h00000C81, 32'hFFFFFFBF);
        rchk(ADDR_STATUS, 32'h00000C00, 32'hFFFFFFBF);
        for (int k = 0; k < 4; k++) begin
            rchk(ADDR_RX, 32'(8'hC3 - 8'(k)), 32'hFF);
            rchk(ADDR_STATUS, 32'(((3 - k) << 8) | ((3 - k) > 1 ? 32'h800 : 32'h0)), 32'hF00);
        end
        for (int k = 0; k < 5; k++) begin
            chk({24'h0, u_slave.got[k]}, {24'h0, txb[k]}, 32'hFF);
        end
    endtask

    task automatic t_underflow();
        wr(ADDR_CTRL, 32'h1022);
        rchk(ADDR_RX, 32'h0, 32'hFFFFFF00);
        wait_idle();
        rchk(ADDR_STATUS, 32'h00000011, 32'hFFFFFFFF);
        rchk(ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
        wr(ADDR_CTRL, 32'h102A);
        rchk(ADDR_RX, 32'h0, 32'hFFFFFF00);
        wait_idle();
        rchk(ADDR_STATUS, 32'h00000010, 32'hFFFFFFFF);
    endtask

    task automatic t_tx_irq();
        wr(ADDR_CTRL, 32'h4062);
        wr(ADDR_DIV, 32'h2);
        rchk(ADDR_DIV, 32'h0, 32'hFFFFFFFF);
        wr(ADDR_TX, 32'hA5);
        measure(6);
        wait_idle();
        rchk(ADDR_STATUS, 32'h00000100, 32'hFFFFFFFF);
        wr(ADDR_TX, 32'h96);
        wait_idle();
        rchk(ADDR_STATUS, 32'h00000221, 32'hFFFFFFFF);
    endtask

    // loopback with clock polarity and phase set, two bytes in one continuous frame
    task automatic t_loop_cont();
        wr(ADDR_CTRL, 32'h1000);
        wr(ADDR_CTRL, 32'h0837);
        wr(ADDR_TX, 32'h6B);
        wr(ADDR_TX, 32'hD4);
        wait_idle();
        rchk(ADDR_STATUS, 32'h00000A41, 32'hFFFFFFFF);
        rchk(ADDR_RX, 32'h6B, 32'hFFFFFFFF);
        rchk(ADDR_RX, 32'hD4, 32'hFFFFFFFF);
    endtask

    // bench as far-side master in mode 0; eight clocks a half period outlast the pin synchroniser
    task automatic t_slave();
        logic [7:0] mb;
        logic [7:0] sb;
        mb = 8'hA3;
        sb = 8'h00;
        wr(ADDR_CTRL, 32'h0020);
        wr(ADDR_TX, 32'h5C);
        m_mosi <= mb[7];
        m_ss_n <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            repeat (8) @(posedge mclk);
            sb = {sb[6:0], miso_w};
            m_sclk <= 1'b1;
            repeat (8) @(posedge mclk);
            mb = {mb[6:0], 1'b0};
            m_sclk <= 1'b0;
            m_mosi <= mb[7];
        end
        repeat (8) @(posedge mclk);
        m_ss_n <= 1'b1;
        chk({24'h0, sb}, 32'h5C, 32'hFF);
        rchk(ADDR_STATUS, 32'h00000140, 32'h00000F4E);
        rchk(ADDR_RX, 32'hA3, 32'hFFFFFFFF);
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        results();
    end

    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_map();
        t_tx_fill();
        t_rx_path();
        t_underflow();
        t_tx_irq();
        t_loop_cont();
        t_slave();
        results();
    end
endmodule
`default_nettype wire
